// ===== logic/nvac_defines.svh
// Offsets, field positions, unlock keys and timing counts for the nonvolatile access block
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH
`define NVAC_ADDR_W 10
`define NVAC_DEPTH 1024
`define NVAC_PADDR_W 8
`define NVAC_OFS_INDEX_LOW 8'h00
`define NVAC_OFS_INDEX_HIGH 8'h04
`define NVAC_OFS_BYTE_BUFFER 8'h08
`define NVAC_OFS_CONTROL 8'h0C
`define NVAC_OFS_UNLOCK 8'h10
`define NVAC_OFS_PFR2 8'h14
`define NVAC_INDEX_HIGH_MASK 8'h03
`define NVAC_BIT_FETCH 0
`define NVAC_BIT_STORE 1
`define NVAC_BIT_PERMIT 2
`define NVAC_BIT_FAULT 3
`define NVAC_BIT_CFG_SEL 6
`define NVAC_BIT_FLASH_SEL 7
`define NVAC_BIT_DONE 4
`define NVAC_UNLOCK_KEY1 8'hA5
`define NVAC_UNLOCK_KEY2 8'h5A
`define NVAC_ERASED_BYTE 8'hFF
`define NVAC_CLK_HZ 10000000
`define NVAC_WRITE_TIME_US 4000
`define NVAC_WRITE_CYCLES (`NVAC_WRITE_TIME_US * (`NVAC_CLK_HZ / 1000000))
`endif

// ===== logic/nvac_pkg.sv
// Types shared by the nonvolatile access block
`include "nvac_defines.svh"
package nvac_pkg;
	typedef enum logic [1:0] {
		TGT_DATA = 2'b00,
		TGT_PROG = 2'b01,
		TGT_CFG = 2'b10
	} nvac_target_type;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} nvac_op_type;

	typedef enum logic [1:0] {
		UL_LOCKED = 2'b00,
		UL_HALF = 2'b01,
		UL_ARMED = 2'b10
	} nvac_unlock_type;

	typedef struct packed {
		logic flash_select;
		logic config_space_select;
		logic store_fault_flag;
		logic store_permit;
		logic store_trigger;
		logic fetch_trigger;
	} nvac_ctrl_type;

	typedef struct packed {
		logic write;
		nvac_target_type target;
		logic [`NVAC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} nvac_ext_cmd_type;
endpackage

// ===== logic/nvac_store.sv
// Data nonvolatile byte array with timed erase-before-write
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
module nvac_store
	import nvac_pkg::*;
#(
	parameter int ADDR_W = `NVAC_ADDR_W,
	parameter int DEPTH = `NVAC_DEPTH,
	parameter int WRITE_CYCLES = `NVAC_WRITE_CYCLES
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic rd_start,
	input wire logic wr_start,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_done,
	output logic wr_done
);
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ERASE = CNT_W'(WRITE_CYCLES / 2);

	// Contents are not reset: the array must survive a reset
	logic [7:0] mem_q [DEPTH];
	logic [CNT_W-1:0] cnt_q;
	logic busy_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] wdata_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			busy_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (wr_start && !busy_q)
		begin
			busy_q <= 1'b1;
			cnt_q <= CNT_LAST;
		end
		else if (busy_q)
		begin
			if (cnt_q == '0)
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (wr_start && !busy_q)
		begin
			addr_q <= addr;
			wdata_q <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (busy_q && cnt_q == CNT_ERASE)
			mem_q[addr_q] <= `NVAC_ERASED_BYTE;
		else if (busy_q && cnt_q == '0)
			mem_q[addr_q] <= wdata_q;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			wr_done <= 1'b0;
		else
			wr_done <= busy_q && cnt_q == '0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rd_done <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			rd_done <= rd_start;
			if (rd_start)
				rdata <= mem_q[addr];
		end
	end
endmodule
`default_nettype wire

// ===== logic/nvac_top.sv
// Register-level access control for the nonvolatile byte memory
// Behaviour
// - 10-bit address from low plus two high bits
// - Flash select picks program memory over data
// - Config select overrides, targets configuration space
// - Writes proceed only with store permit set
// - Store permit clears at reset
// - Data write completes when programming timer expires; external write on ext_ack
// - Fault flag marks improper writes and writes aborted by a one-cycle reset
// - Store trigger set-only; hardware clears at end
// - Done flag set on write end; software clears
// - Triggers start read or erase/write operations
// - Fetch trigger ignored while flash select set
// - Unlock port stores nothing, reads zero
// - Byte buffer holds read or write data
// - Byte write erases location before programming
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
module nvac_top
	import nvac_pkg::*;
#(
	parameter int WRITE_CYCLES = `NVAC_WRITE_CYCLES,
	parameter logic [7:0] UNLOCK_KEY1 = `NVAC_UNLOCK_KEY1,
	parameter logic [7:0] UNLOCK_KEY2 = `NVAC_UNLOCK_KEY2
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`NVAC_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ext_req,
	output var nvac_ext_cmd_type ext_cmd,
	input wire logic ext_ack,
	input wire logic [7:0] ext_rdata,
	output logic done_flag
);
	logic [7:0] index_low_q;
	logic [1:0] index_high_q;
	logic [7:0] buffer_q;
	nvac_ctrl_type ctrl_q;
	nvac_op_type op_q;
	nvac_unlock_type unlock_q;
	logic done_q;
	logic ext_req_q;
	nvac_ext_cmd_type ext_cmd_q;
	logic [31:0] prdata_q;
	logic [`NVAC_ADDR_W-1:0] nv_addr;
	nvac_target_type target;
	logic wr_access;
	logic setup;
	logic hit;
	logic ctrl_wr;
	logic launch_rd;
	logic launch_wr;
	logic rd_finish;
	logic wr_finish;
	logic st_rd_done;
	logic st_wr_done;
	logic [7:0] st_rdata;
	logic unlock_armed;

	function automatic logic reg_hit(input logic [`NVAC_PADDR_W-1:0] a,
		input logic [`NVAC_PADDR_W-1:0] ofs);
		reg_hit = a == ofs;
	endfunction

	// Target decode is shared by the launch and request paths
	function automatic nvac_target_type target_of(input nvac_ctrl_type c);
		if (c.config_space_select)
			target_of = TGT_CFG;
		else if (c.flash_select)
			target_of = TGT_PROG;
		else
			target_of = TGT_DATA;
	endfunction

	function automatic logic [7:0] ctrl_byte(input nvac_ctrl_type c);
		logic [7:0] b;
		b = 8'h00;
		b[`NVAC_BIT_FLASH_SEL] = c.flash_select;
		b[`NVAC_BIT_CFG_SEL] = c.config_space_select;
		b[`NVAC_BIT_FAULT] = c.store_fault_flag;
		b[`NVAC_BIT_PERMIT] = c.store_permit;
		b[`NVAC_BIT_STORE] = c.store_trigger;
		b[`NVAC_BIT_FETCH] = c.fetch_trigger;
		ctrl_byte = b;
	endfunction

	assign nv_addr = {index_high_q, index_low_q};
	assign target = target_of(ctrl_q);
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite && pstrb[0];
	assign hit = reg_hit(paddr, `NVAC_OFS_INDEX_LOW) || reg_hit(paddr, `NVAC_OFS_INDEX_HIGH)
		|| reg_hit(paddr, `NVAC_OFS_BYTE_BUFFER) || reg_hit(paddr, `NVAC_OFS_CONTROL)
		|| reg_hit(paddr, `NVAC_OFS_UNLOCK) || reg_hit(paddr, `NVAC_OFS_PFR2);
	assign ctrl_wr = wr_access && reg_hit(paddr, `NVAC_OFS_CONTROL);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_q;
	assign ext_req = ext_req_q;
	assign ext_cmd = ext_cmd_q;
	assign done_flag = done_q;
	assign unlock_armed = unlock_q == UL_ARMED;

	// Operations launch one cycle after the trigger is set
	assign launch_rd = op_q == OP_IDLE && ctrl_q.fetch_trigger;
	assign launch_wr = op_q == OP_IDLE && ctrl_q.store_trigger && !ctrl_q.fetch_trigger;
	assign rd_finish = op_q == OP_READ && (st_rd_done || (ext_req_q && ext_ack));
	assign wr_finish = op_q == OP_WRITE && (st_wr_done || (ext_req_q && ext_ack));

	// Only data space lives here; other spaces go out on ext_req
	nvac_store #(
		.ADDR_W(`NVAC_ADDR_W),
		.DEPTH(`NVAC_DEPTH),
		.WRITE_CYCLES(WRITE_CYCLES)
	) u_store (
		.clk(clk),
		.srst(srst),
		.rd_start(launch_rd && target == TGT_DATA),
		.wr_start(launch_wr && target == TGT_DATA),
		.addr(nv_addr),
		.wdata(buffer_q),
		.rdata(st_rdata),
		.rd_done(st_rd_done),
		.wr_done(st_wr_done)
	);

	// One operation at a time; fetch wins over store
	always_ff @(posedge clk)
	begin
		if (srst)
			op_q <= OP_IDLE;
		else
		begin
			case (op_q)
				OP_IDLE:
				begin
					if (launch_rd)
						op_q <= OP_READ;
					else if (launch_wr)
						op_q <= OP_WRITE;
				end
				OP_READ:
				begin
					if (rd_finish)
						op_q <= OP_IDLE;
				end
				OP_WRITE:
				begin
					if (wr_finish)
						op_q <= OP_IDLE;
				end
				default:
					op_q <= OP_IDLE;
			endcase
		end
	end

	// Program and configuration spaces live outside; held request until ack
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ext_req_q <= 1'b0;
			ext_cmd_q <= '0;
		end
		else if ((launch_rd || launch_wr) && target != TGT_DATA)
		begin
			ext_req_q <= 1'b1;
			ext_cmd_q.write <= launch_wr && !launch_rd;
			ext_cmd_q.target <= target;
			ext_cmd_q.addr <= nv_addr;
			ext_cmd_q.wdata <= buffer_q;
		end
		else if (ext_req_q && ext_ack)
			ext_req_q <= 1'b0;
	end

	// Address registers are frozen while an operation runs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			index_low_q <= 8'h00;
			index_high_q <= 2'b00;
		end
		else if (wr_access && op_q == OP_IDLE)
		begin
			if (reg_hit(paddr, `NVAC_OFS_INDEX_LOW))
				index_low_q <= pwdata[7:0];
			if (reg_hit(paddr, `NVAC_OFS_INDEX_HIGH))
				index_high_q <= pwdata[1:0];
		end
	end

	// A finished read wins over a bus write
	always_ff @(posedge clk)
	begin
		if (srst)
			buffer_q <= 8'h00;
		else if (rd_finish)
			buffer_q <= st_rd_done ? st_rdata : ext_rdata;
		else if (wr_access && op_q == OP_IDLE && reg_hit(paddr, `NVAC_OFS_BYTE_BUFFER))
			buffer_q <= pwdata[7:0];
	end

	// Any bus write with pstrb[0] set, other than a key, breaks the unlock sequence
	always_ff @(posedge clk)
	begin
		if (srst)
			unlock_q <= UL_LOCKED;
		else if (wr_access && reg_hit(paddr, `NVAC_OFS_UNLOCK))
		begin
			if (pwdata[7:0] == UNLOCK_KEY1)
				unlock_q <= UL_HALF;
			else if (unlock_q == UL_HALF && pwdata[7:0] == UNLOCK_KEY2)
				unlock_q <= UL_ARMED;
			else
				unlock_q <= UL_LOCKED;
		end
		else if (wr_access)
			unlock_q <= UL_LOCKED;
	end

	// A one-cycle reset mid-write leaves the fault flag set; a longer reset clears it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_q <= '0;
			ctrl_q.store_fault_flag <= op_q == OP_WRITE;
		end
		else
		begin
			if (ctrl_wr && op_q == OP_IDLE && !ctrl_q.store_trigger && !ctrl_q.fetch_trigger)
			begin
				ctrl_q.flash_select <= pwdata[`NVAC_BIT_FLASH_SEL];
				ctrl_q.config_space_select <= pwdata[`NVAC_BIT_CFG_SEL];
				ctrl_q.store_permit <= pwdata[`NVAC_BIT_PERMIT];
				ctrl_q.store_fault_flag <= pwdata[`NVAC_BIT_FAULT];
				if (pwdata[`NVAC_BIT_FETCH] && !pwdata[`NVAC_BIT_FLASH_SEL])
					ctrl_q.fetch_trigger <= 1'b1;
				else if (pwdata[`NVAC_BIT_STORE])
				begin
					if (pwdata[`NVAC_BIT_PERMIT] && ctrl_q.store_permit && unlock_armed)
						ctrl_q.store_trigger <= 1'b1;
					else
						ctrl_q.store_fault_flag <= 1'b1;
				end
			end
			if (rd_finish)
				ctrl_q.fetch_trigger <= 1'b0;
			if (wr_finish)
				ctrl_q.store_trigger <= 1'b0;
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			done_q <= 1'b0;
		else if (wr_finish)
			done_q <= 1'b1;
		else if (wr_access && reg_hit(paddr, `NVAC_OFS_PFR2))
			done_q <= pwdata[`NVAC_BIT_DONE];
	end

	// Captured at setup so the access phase needs no wait state
	always_ff @(posedge clk)
	begin
		if (srst)
			prdata_q <= 32'h0000_0000;
		else if (setup)
		begin
			prdata_q <= 32'h0000_0000;
			if (reg_hit(paddr, `NVAC_OFS_INDEX_LOW))
				prdata_q[7:0] <= index_low_q;
			else if (reg_hit(paddr, `NVAC_OFS_INDEX_HIGH))
				prdata_q[7:0] <= {6'h00, index_high_q} & `NVAC_INDEX_HIGH_MASK;
			else if (reg_hit(paddr, `NVAC_OFS_BYTE_BUFFER))
				prdata_q[7:0] <= buffer_q;
			else if (reg_hit(paddr, `NVAC_OFS_CONTROL))
				prdata_q[7:0] <= ctrl_byte(ctrl_q);
			else if (reg_hit(paddr, `NVAC_OFS_UNLOCK))
				prdata_q[7:0] <= 8'h00;
			else if (reg_hit(paddr, `NVAC_OFS_PFR2))
				prdata_q[`NVAC_BIT_DONE] <= done_q;
		end
	end
endmodule
`default_nettype wire

// ===== test/nvac_sva.sv
// Port assertions for the nonvolatile access block
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
module nvac_sva
	import nvac_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`NVAC_PADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic ext_req,
	input wire nvac_ext_cmd_type ext_cmd,
	input wire logic ext_ack,
	input wire logic done_flag
);
	logic rd_acc;
	assign rd_acc = psel && penable && !pwrite;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	a_unlock_reads_zero: assert property (rd_acc && paddr == `NVAC_OFS_UNLOCK |-> prdata == 32'h0)
		else $error("unlock port read not zero");
	a_high_index_masked: assert property (rd_acc && paddr == `NVAC_OFS_INDEX_HIGH |-> prdata[31:2] == 30'h0)
		else $error("high index upper bits not zero");
	a_byte_wide_read: assert property (rd_acc |-> prdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_done_holds: assert property (done_flag && !(psel && penable && pwrite && paddr == `NVAC_OFS_PFR2) |=> done_flag)
		else $error("done flag dropped without software clear");
	a_done_read: assert property (psel && !penable && !pwrite && paddr == `NVAC_OFS_PFR2 |=> prdata[4] == $past(done_flag))
		else $error("done flag not at bit 4");
	a_ext_target: assert property ($rose(ext_req) |-> ext_cmd.target != TGT_DATA)
		else $error("external request for data memory");
	a_ext_hold: assert property (ext_req && !ext_ack |=> ext_req && $stable(ext_cmd))
		else $error("external request changed before answer");
	a_ext_done: assert property (ext_req && ext_ack && ext_cmd.write |=> done_flag)
		else $error("done flag not set at write end");
endmodule
bind nvac_top nvac_sva u_sva (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .ext_req(ext_req), .ext_cmd(ext_cmd),
	.ext_ack(ext_ack), .done_flag(done_flag));
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the nonvolatile access block
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.svh"
module tb
	import nvac_pkg::*;
;
	localparam logic [7:0] IL = `NVAC_OFS_INDEX_LOW;
	localparam logic [7:0] IH = `NVAC_OFS_INDEX_HIGH;
	localparam logic [7:0] BUF = `NVAC_OFS_BYTE_BUFFER;
	localparam logic [7:0] CTRL = `NVAC_OFS_CONTROL;
	localparam logic [7:0] UNL = `NVAC_OFS_UNLOCK;
	localparam logic [7:0] PFR = `NVAC_OFS_PFR2;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_req;
	nvac_ext_cmd_type ext_cmd;
	logic ext_ack = 1'b0;
	logic [7:0] ext_rdata = 8'h00;
	logic done_flag;
	nvac_target_type last_tgt;
	nvac_ext_cmd_type last_cmd;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int n_tests = 0;
	// Short store time keeps the run brief
	nvac_top #(.WRITE_CYCLES(8)) u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_req(ext_req), .ext_cmd(ext_cmd),
		.ext_ack(ext_ack), .ext_rdata(ext_rdata), .done_flag(done_flag));
	initial
		forever #50 clk = ~clk;
	// Far side answers one cycle after each request
	always @(posedge clk)
	begin
		ext_ack <= ext_req && !ext_ack;
		ext_rdata <= ext_cmd.addr[7:0] ^ 8'h5A;
		if (ext_req)
		begin
			last_tgt <= ext_cmd.target;
			last_cmd <= ext_cmd;
		end
	end
	task final_report;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task tout;
		$display("[ERR] wait expected done seen timeout");
		mismatches++;
		final_report;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 8);
		if (pready !== 1'b1)
			tout;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		int i;
		i = 0;
		do
		begin
			xfer(1'b0, a, 32'h0);
			i++;
		end
		while ((rd & m) !== 32'h0 && i < 40);
		if ((rd & m) !== 32'h0)
			tout;
	endtask
	// Permit first, then both keys, since any other write disarms
	task store(input logic [31:0] c);
		xfer(1'b1, CTRL, c | 32'h04);
		xfer(1'b1, UNL, {24'h0, `NVAC_UNLOCK_KEY1});
		xfer(1'b1, UNL, {24'h0, `NVAC_UNLOCK_KEY2});
		xfer(1'b1, CTRL, c | 32'h06);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rdc("ctrl", CTRL, 32'h0);
		rdc("flags", PFR, 32'h0);
		rdc("unlock", UNL, 32'h0);
		xfer(1'b1, IH, 32'hFF);
		rdc("idx_hi", IH, 32'h03);
		xfer(1'b1, IL, 32'hFF);
		rdc("idx_lo", IL, 32'hFF);
		xfer(1'b1, CTRL, 32'h02);
		rdc("ctrl", CTRL, 32'h08);
		$display("end reset and index");
		xfer(1'b1, CTRL, 32'h0);
		xfer(1'b1, BUF, 32'h5C);
		store(32'h0);
		rdc("ctrl", CTRL, 32'h06);
		xfer(1'b1, CTRL, 32'h04);
		rdc("ctrl", CTRL, 32'h06);
		poll(CTRL, 32'h02);
		chk("done", 32'h1, {31'h0, done_flag});
		rdc("flags", PFR, 32'h10);
		rdc("ctrl", CTRL, 32'h04);
		xfer(1'b1, PFR, 32'h0);
		rdc("flags", PFR, 32'h0);
		$display("end store");
		xfer(1'b1, BUF, 32'h11);
		xfer(1'b1, CTRL, 32'h01);
		poll(CTRL, 32'h01);
		rdc("buf", BUF, 32'h5C);
		xfer(1'b1, CTRL, 32'h81);
		rdc("ctrl", CTRL, 32'h80);
		chk("req", 32'h0, {31'h0, ext_req});
		$display("end fetch");
		store(32'h80);
		poll(CTRL, 32'h02);
		chk("tgt", {30'h0, TGT_PROG}, {30'h0, last_tgt});
		chk("cmd", {11'h0, 1'b1, TGT_PROG, 10'h3FF, 8'h5C}, {11'h0, last_cmd});
		chk("done", 32'h1, {31'h0, done_flag});
		xfer(1'b1, CTRL, 32'h41);
		poll(CTRL, 32'h01);
		chk("tgt", {30'h0, TGT_CFG}, {30'h0, last_tgt});
		chk("cmd", {11'h0, 1'b0, TGT_CFG, 10'h3FF, 8'h5C}, {11'h0, last_cmd});
		rdc("buf", BUF, 32'hA5);
		xfer(1'b0, 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		$display("end external");
		store(32'h0);
		// Let the write launch so the reset cuts it short
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		rdc("ctrl", CTRL, 32'h08);
		$display("end abort");
		final_report;
	end
endmodule
`default_nettype wire
